// >>> rtl/mcs_map.svh
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

// Configuration byte layout
`define MCS_CFG_W 8
`define MCS_BIT_RESET 7
`define MCS_BIT_PLL 6
`define MCS_BIT_OSC 5
`define MCS_DRV_HI 4
`define MCS_DRV_LO 3
`define MCS_SEL_HI 2
`define MCS_SEL_LO 0
`define MCS_CFG_RESET 8'h00

// First source select code that is a multiplier tap
`define MCS_SEL_FIRST_TAP 3'h3
`define MCS_SEL_XTAL 3'h2

// Switchover stall
`define MCS_CLK_PERIOD_NS 10
`define MCS_STALL_TIME_US 100
`define MCS_STALL_CYCLES \
    ((`MCS_STALL_TIME_US * 1000) / `MCS_CLK_PERIOD_NS)
`define MCS_CNT_W 14

`endif

// >>> rtl/mcs_pkg.sv
package mcs_pkg;
    `include "mcs_map.svh"

    typedef enum logic [2:0] {
        MCS_SRC_RC_FAST,
        MCS_SRC_RC_SLOW,
        MCS_SRC_XTAL,
        MCS_SRC_PLL_X1,
        MCS_SRC_PLL_X2,
        MCS_SRC_PLL_X4,
        MCS_SRC_PLL_X8,
        MCS_SRC_PLL_X16
    } mcs_src_t;

    typedef enum logic [1:0] {
        MCS_DRV_EXT_INPUT,
        MCS_DRV_FB_2000,
        MCS_DRV_FB_1000,
        MCS_DRV_FB_500
    } mcs_drive_t;

    typedef struct packed {
        logic [`MCS_CFG_W-1:0] cfg;
        mcs_src_t active_src;
        logic [`MCS_CNT_W-1:0] cnt;
        logic stall;
        logic chip_reset;
    } mcs_state_t;
endpackage

// >>> rtl/mcs_master_clock_select.sv
`timescale 1ns/1ps
`include "mcs_map.svh"
module mcs_master_clock_select #(
    parameter int STALL_CYCLES = `MCS_STALL_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clock_config_write_instr,
    input wire logic [7:0] cfg_wr_data,
    output logic cfg_wr_ready,
    output logic stall,
    output logic chip_reset_req,
    output logic multiplier_enable,
    output logic oscillator_enable,
    output logic drive_mode_hi,
    output logic drive_mode_lo,
    output logic osc_feedback_on,
    output logic pll_ref_enable,
    output mcs_pkg::mcs_src_t active_source,
    output logic [2:0] pll_tap,
    output logic source_ready
);
    import mcs_pkg::*;

    // Prerequisites of a source code
    function automatic logic src_ok(input logic [2:0] sel,
                                    input logic osc, input logic pll);
        if (sel >= `MCS_SEL_FIRST_TAP) begin
            src_ok = osc & pll;
        end else if (sel == `MCS_SEL_XTAL) begin
            src_ok = osc;
        end else begin
            src_ok = 1'b1;
        end
    endfunction

    localparam logic [`MCS_CNT_W-1:0] STALL_LOAD =
        `MCS_CNT_W'(STALL_CYCLES);

    mcs_state_t q, d;
    logic wr_acc;

    // No new write while the chip is stalled
    assign cfg_wr_ready = !q.stall;
    assign wr_acc = clock_config_write_instr && cfg_wr_ready;

    always_comb begin
        d = q;
        d.chip_reset = 1'b0;
        if (q.stall) begin
            d.cnt = q.cnt - `MCS_CNT_W'(1);
            if (q.cnt == `MCS_CNT_W'(1)) begin
                d.stall = 1'b0;
                // Take over new source only at end of stall
                d.active_src = mcs_src_t'(q.cfg[`MCS_SEL_HI:`MCS_SEL_LO]);
            end
        end
        if (wr_acc) begin
            // Store fields, enables act at once
            d.cfg = cfg_wr_data;
            d.cfg[`MCS_BIT_RESET] = 1'b0;
            d.chip_reset = cfg_wr_data[`MCS_BIT_RESET];
            d.stall = 1'b1;
            d.cnt = STALL_LOAD;
        end
        if (sys_rst) begin
            d.cfg = `MCS_CFG_RESET;
            d.active_src = MCS_SRC_RC_FAST;
            d.cnt = '0;
            d.stall = 1'b0;
            d.chip_reset = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign stall = q.stall;
    assign chip_reset_req = q.chip_reset;
    assign multiplier_enable = q.cfg[`MCS_BIT_PLL];
    assign oscillator_enable = q.cfg[`MCS_BIT_OSC];
    assign drive_mode_hi = q.cfg[`MCS_DRV_HI];
    assign drive_mode_lo = q.cfg[`MCS_DRV_LO];
    // Feedback only for crystal modes
    assign osc_feedback_on = oscillator_enable &&
        (mcs_drive_t'(q.cfg[`MCS_DRV_HI:`MCS_DRV_LO]) != MCS_DRV_EXT_INPUT);
    assign pll_ref_enable = oscillator_enable && multiplier_enable;
    assign active_source = q.active_src;
    // Tap index 0..4 for x1..x16
    assign pll_tap = (q.active_src >= `MCS_SEL_FIRST_TAP) ?
        3'(q.active_src - `MCS_SEL_FIRST_TAP) : 3'h0;
    assign source_ready = src_ok(q.active_src, oscillator_enable,
                                 multiplier_enable);

    // Stall timing and refusal
    chk_write_stalls: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_acc |=> stall ##1 stall)
        else $error("write did not start stall");
    chk_stall_ends: assert property (
        @(posedge clk) disable iff (sys_rst)
        (stall && q.cnt == `MCS_CNT_W'(1)) |=> !stall)
        else $error("stall did not end on count");
    chk_stall_bound: assert property (
        @(posedge clk) disable iff (sys_rst)
        stall |-> (q.cnt != '0 && q.cnt <= STALL_LOAD))
        else $error("stall counter out of range");
    chk_stall_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_acc |=> q.cnt == STALL_LOAD)
        else $error("stall counter not loaded");
    chk_stall_count: assert property (
        @(posedge clk) disable iff (sys_rst)
        (stall && q.cnt != `MCS_CNT_W'(1)) |=>
        (stall && q.cnt == $past(q.cnt) - `MCS_CNT_W'(1)))
        else $error("stall counter skipped a step");
    chk_stall_cause: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(stall) |-> $past(wr_acc))
        else $error("stall without accepted write");
    chk_refuse_busy: assert property (
        @(posedge clk) disable iff (sys_rst)
        (clock_config_write_instr && stall) |=> $stable(q.cfg))
        else $error("write taken during stall");

    // Reset request
    chk_reset_pulse: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_acc && cfg_wr_data[`MCS_BIT_RESET]) |=> chip_reset_req ##1
        !chip_reset_req)
        else $error("reset bit did not give one pulse");
    chk_reset_cause: assert property (
        @(posedge clk) disable iff (sys_rst)
        chip_reset_req |->
        ($past(wr_acc) && $past(cfg_wr_data[`MCS_BIT_RESET])))
        else $error("reset pulse without reset write");
    chk_no_reset_pulse: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_acc && !cfg_wr_data[`MCS_BIT_RESET]) |=> !chip_reset_req)
        else $error("reset pulse from a plain write");
    chk_reset_bit_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_acc |=> !q.cfg[`MCS_BIT_RESET])
        else $error("reset bit kept in stored byte");

    // Field storage and decode
    chk_cfg_update: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_acc |=> {multiplier_enable, oscillator_enable, drive_mode_hi,
        drive_mode_lo} == $past(cfg_wr_data[6:3]))
        else $error("config fields not stored");
    chk_sel_store: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_acc |=>
        q.cfg[`MCS_SEL_HI:`MCS_SEL_LO] == $past(cfg_wr_data[2:0]))
        else $error("select field not stored");
    chk_fields_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!wr_acc && !sys_rst) |=> $stable({multiplier_enable,
        oscillator_enable, drive_mode_hi, drive_mode_lo}))
        else $error("fields changed without a write");
    chk_fb_mode: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_acc |=> osc_feedback_on == ($past(cfg_wr_data[5]) &&
        ($past(cfg_wr_data[4:3]) != 2'b00)))
        else $error("feedback mode does not follow write");
    chk_ref_gate: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_acc |=> pll_ref_enable == ($past(cfg_wr_data[5]) &&
        $past(cfg_wr_data[6])))
        else $error("reference gate does not follow enables");

    // Source switchover
    chk_sel_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (stall && $past(stall)) |-> $stable(active_source))
        else $error("source changed during stall");
    chk_idle_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!stall && !$past(stall) && !$past(sys_rst)) |->
        $stable(active_source))
        else $error("source changed outside a switchover");
    chk_sel_takeover: assert property (
        @(posedge clk) disable iff (sys_rst)
        ($fell(stall) && !$past(sys_rst)) |->
        active_source == $past(q.cfg[2:0]))
        else $error("new source not taken at stall end");
    chk_free_switch: assert property (
        @(posedge clk) disable iff (sys_rst)
        ($fell(stall) && oscillator_enable && multiplier_enable) |->
        source_ready)
        else $error("source not usable with both enabled");
    chk_ready_rc: assert property (
        @(posedge clk) disable iff (sys_rst)
        (active_source inside {MCS_SRC_RC_FAST, MCS_SRC_RC_SLOW}) |->
        source_ready)
        else $error("internal source not ready");
    chk_ready_xtal: assert property (
        @(posedge clk) disable iff (sys_rst)
        (active_source == MCS_SRC_XTAL) |->
        source_ready == oscillator_enable)
        else $error("crystal source ready wrong");
    chk_ready_pll: assert property (
        @(posedge clk) disable iff (sys_rst)
        (active_source >= MCS_SRC_PLL_X1) |->
        source_ready == pll_ref_enable)
        else $error("multiplier source ready wrong");
    chk_tap_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        (active_source < MCS_SRC_PLL_X1) |-> pll_tap == 3'h0)
        else $error("tap set for a direct source");
    chk_tap_x1: assert property (
        @(posedge clk) disable iff (sys_rst)
        (active_source == MCS_SRC_PLL_X1) |-> pll_tap == 3'h0)
        else $error("wrong tap for x1");
    chk_tap_x4: assert property (
        @(posedge clk) disable iff (sys_rst)
        (active_source == MCS_SRC_PLL_X4) |-> pll_tap == 3'h2)
        else $error("wrong tap for x4");
    chk_tap_map: assert property (
        @(posedge clk) disable iff (sys_rst)
        (active_source == MCS_SRC_PLL_X16) |-> pll_tap == 3'h4)
        else $error("wrong tap for x16");

    cov_switch_pll: cover property (@(posedge clk) disable iff (sys_rst)
        $fell(stall) && active_source == MCS_SRC_PLL_X16 && source_ready);
    cov_soft_reset: cover property (@(posedge clk) disable iff (sys_rst)
        chip_reset_req);
    cov_refused: cover property (@(posedge clk) disable iff (sys_rst)
        clock_config_write_instr && stall);
    cov_crystal_fb: cover property (@(posedge clk) disable iff (sys_rst)
        osc_feedback_on && pll_ref_enable);
    cov_xtal_direct: cover property (@(posedge clk) disable iff (sys_rst)
        $fell(stall) && active_source == MCS_SRC_XTAL && source_ready);
endmodule

// >>> tb/mcs_master_clock_select_tb.sv
`timescale 1ns/1ps
module mcs_master_clock_select_tb;
    import mcs_pkg::*;
    localparam int SC = 8;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clock_config_write_instr = 1'b0;
    logic [7:0] cfg_wr_data = 8'h00;
    logic cfg_wr_ready, stall, chip_reset_req, multiplier_enable;
    logic oscillator_enable, drive_mode_hi, drive_mode_lo, osc_feedback_on;
    logic pll_ref_enable, source_ready;
    logic [2:0] pll_tap;
    mcs_src_t active_source;
    logic [2:0] old_sel = 3'h0;
    logic [7:0] cfg_copy = 8'h00;
    int failures = 0;
    int num_checks = 0;

    mcs_master_clock_select #(.STALL_CYCLES(SC)) uut (
        .clk(clk), .sys_rst(sys_rst),
        .clock_config_write_instr(clock_config_write_instr),
        .cfg_wr_data(cfg_wr_data), .cfg_wr_ready(cfg_wr_ready),
        .stall(stall), .chip_reset_req(chip_reset_req),
        .multiplier_enable(multiplier_enable),
        .oscillator_enable(oscillator_enable),
        .drive_mode_hi(drive_mode_hi), .drive_mode_lo(drive_mode_lo),
        .osc_feedback_on(osc_feedback_on), .pll_ref_enable(pll_ref_enable),
        .active_source(active_source), .pll_tap(pll_tap),
        .source_ready(source_ready));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        logic [2:0] s;
        s = d[2:0];
        @(posedge clk);
        clock_config_write_instr <= 1'b1;
        cfg_wr_data <= d;
        @(posedge clk);
        clock_config_write_instr <= 1'b0;
        #1;
        chk(stall, 8'h01);
        chk(cfg_wr_ready, 8'h00);
        chk({multiplier_enable, oscillator_enable}, d[6:5]);
        chk({drive_mode_hi, drive_mode_lo}, d[4:3]);
        chk(osc_feedback_on, d[5] && d[4:3] != 2'b00);
        chk(pll_ref_enable, d[5] && d[6]);
        chk(chip_reset_req, d[7]);
        chk(active_source, old_sel);
        cfg_copy = d;
        // Strobe during the stall must be ignored
        @(posedge clk);
        clock_config_write_instr <= 1'b1;
        cfg_wr_data <= ~d & 8'h7F;
        #1 chk(chip_reset_req, 8'h00);
        @(posedge clk);
        clock_config_write_instr <= 1'b0;
        #1 chk({multiplier_enable, oscillator_enable, drive_mode_hi,
            drive_mode_lo}, cfg_copy[6:3]);
        repeat (SC - 3) @(posedge clk);
        #1 chk(stall, 8'h01);
        chk(active_source, old_sel);
        @(posedge clk);
        #1 chk(stall, 8'h00);
        chk(active_source, s);
        chk(pll_tap, (s >= 3'h3) ? s - 3'h3 : 3'h0);
        chk(source_ready, (s < 3'h2) ? 1'b1 :
            (s == 3'h2) ? d[5] : (d[5] & d[6]));
        chk(cfg_wr_ready, 8'h01);
        old_sel = s;
    endtask

    initial begin
        repeat (64 * (SC + 4)) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk(active_source, 8'h00);
        chk({stall, chip_reset_req, cfg_wr_ready}, 8'h01);
        wr(8'h07);
        wr(8'h02);
        for (int i = 0; i < 8; i++) begin
            wr(8'h60 | {3'h0, i[1:0], i[2:0]});
        end
        // Enable both, wait a scaled settling span, then pick x16
        wr(8'h68);
        repeat (SC) @(posedge clk);
        wr(8'h6F);
        wr(8'hA3);
        wr(8'h41);
        // Chip reset request returns as a reset in mid-stall
        @(posedge clk);
        clock_config_write_instr <= 1'b1;
        cfg_wr_data <= 8'hFE;
        @(posedge clk);
        clock_config_write_instr <= 1'b0;
        #1 chk(chip_reset_req, 8'h01);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk({stall, chip_reset_req, cfg_wr_ready}, 8'h01);
        chk({multiplier_enable, oscillator_enable, drive_mode_hi,
            drive_mode_lo}, 8'h00);
        chk(active_source, 8'h00);
        old_sel = 3'h0;
        wr(8'h01);
        give_verdict();
    end
endmodule
